// ==== rtl/icfg_bank.sv ====
/*
  Configuration register bank behind the index, write and relocatable readback ports.
  Assumes host I/O cycles arrive as pin-level io_wr/io_rd strobes, with address and data held while a strobe is high.
*/
`timescale 1ns/1ps
module icfg_bank
#(
  parameter int NUM_FUNC = icfg_pkg::NFUNC
)
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic arst_n,
  // Mode strap and host I/O cycle.
  input wire logic auto_config_select,
  input wire logic io_wr_raw,
  input wire logic io_rd_raw,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  // Read answer.
  output logic [7:0] io_rdata,
  output logic io_rdata_valid,
  // Function requests from the function cores.
  input wire logic [icfg_pkg::NFUNC-1:0] func_irq_in,
  input wire logic [icfg_pkg::NFUNC-1:0] func_drq_in,
  // Function configuration outputs.
  output logic [icfg_pkg::NFUNC-1:0] func_active,
  output logic [icfg_pkg::NFUNC-1:0] func_io_write,
  output logic [icfg_pkg::NFUNC-1:0] func_irq_out,
  output logic [icfg_pkg::NFUNC-1:0] func_drq_out,
  output logic [7:0] power_saving,
  output logic codec_single_dma
);
  import icfg_pkg::*;

  logic [1:0] wr_sync_reg;
  logic [1:0] rd_sync_reg;
  logic wr_prev_reg;
  logic rd_prev_reg;
  logic [1:0] cfg_mode_sync_reg;
  logic [15:0] addr_meta_reg;
  logic [15:0] addr_sync_reg;
  logic [7:0] wdata_meta_reg;
  logic [7:0] wdata_sync_reg;
  logic wr_pulse;
  logic rd_pulse;
  logic cfg_mode;
  logic [7:0] index_reg;
  logic [7:0] locator_reg;
  logic [7:0] func_sel_reg;
  logic [7:0] power_reg;
  logic [NFUNC-1:0] active_reg;
  logic [1:0] range_chk_reg [NFUNC];
  logic [15:0] base_reg [NFUNC];
  logic [3:0] irq_level_reg [NFUNC];
  logic [2:0] dma_cap_reg [NFUNC];
  logic [2:0] dma_play_reg [NFUNC];
  logic [NFUNC-1:0] hit;
  logic [15:0] readback_addr;
  logic index_hit;
  logic data_hit;
  logic readback_hit;
  logic data_wr;
  logic gl_reset;
  logic func_ok;
  logic [2:0] fsel;
  logic [7:0] rd_next;
  logic rd_valid_next;

  // Strobes, address and data come from pins, so they pass two flip-flops before use.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_sync_reg <= 2'h0;
      rd_sync_reg <= 2'h0;
      cfg_mode_sync_reg <= 2'h0;
      addr_meta_reg <= '0;
      addr_sync_reg <= '0;
      wdata_meta_reg <= ZERO_BYTE;
      wdata_sync_reg <= ZERO_BYTE;
      wr_prev_reg <= 1'b0;
      rd_prev_reg <= 1'b0;
    end
    else
    begin
      wr_sync_reg <= {wr_sync_reg[0], io_wr_raw};
      rd_sync_reg <= {rd_sync_reg[0], io_rd_raw};
      cfg_mode_sync_reg <= {cfg_mode_sync_reg[0], ~auto_config_select};
      addr_meta_reg <= io_addr;
      addr_sync_reg <= addr_meta_reg;
      wdata_meta_reg <= io_wdata;
      wdata_sync_reg <= wdata_meta_reg;
      wr_prev_reg <= wr_sync_reg[1];
      rd_prev_reg <= rd_sync_reg[1];
    end
  end

  function automatic logic [15:0] span_of(input logic [2:0] f);
    unique case (f)
      3'h0: span_of = SPAN_MASK_CODEC;
      3'h1: span_of = SPAN_MASK_LEGACY;
      3'h2: span_of = SPAN_MASK_FM;
      3'h3: span_of = SPAN_MASK_MIDI;
      3'h4: span_of = SPAN_MASK_GAME;
      default: span_of = SPAN_MASK_MODEM;
    endcase
  endfunction : span_of

  function automatic logic [15:0] align_of(input logic [2:0] f);
    unique case (f)
      3'h0: align_of = ALIGN_MASK_CODEC;
      3'h1: align_of = ALIGN_MASK_LEGACY;
      3'h2: align_of = ALIGN_MASK_FM;
      3'h3: align_of = ALIGN_MASK_MIDI;
      3'h4: align_of = ALIGN_MASK_GAME;
      default: align_of = ALIGN_MASK_MODEM;
    endcase
  endfunction : align_of

  // Legacy audio capture accepts only 8-bit channels 0, 1, 3 or none.
  function automatic logic legacy_dma_ok(input logic [2:0] ch);
    legacy_dma_ok = (ch == 3'h0) || (ch == 3'h1) || (ch == 3'h3) || (ch == DMA_NONE);
  endfunction : legacy_dma_ok

  always_comb
  begin
    wr_pulse = wr_sync_reg[1] && !wr_prev_reg;
    rd_pulse = rd_sync_reg[1] && !rd_prev_reg;
    cfg_mode = cfg_mode_sync_reg[1];
    readback_addr = {LOCATOR_HIGH_ZERO, locator_reg, LOCATOR_LOW_ONES};
    index_hit = (addr_sync_reg == INDEX_PORT_ADDR);
    data_hit = (addr_sync_reg == WRITE_PORT_ADDR);
    readback_hit = (addr_sync_reg == readback_addr);
    data_wr = wr_pulse && data_hit && cfg_mode;
    gl_reset = data_wr && (index_reg == IDX_GLOBAL_RESET) && wdata_sync_reg[GLOBAL_RESET_BIT];
    fsel = func_sel_reg[2:0];
    func_ok = (func_sel_reg < 8'(NUM_FUNC));
  end

  // Index persists across data accesses until the host rewrites it.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      index_reg <= ZERO_BYTE;
    else if (wr_pulse && index_hit && cfg_mode)
      index_reg <= wdata_sync_reg;
  end

  // Global registers below the banked area.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      locator_reg <= ZERO_BYTE;
      func_sel_reg <= ZERO_BYTE;
      power_reg <= ZERO_BYTE;
    end
    else if (gl_reset)
    begin
      func_sel_reg <= ZERO_BYTE;
      power_reg <= ZERO_BYTE;
    end
    else if (data_wr)
    begin
      if (index_reg == IDX_LOCATOR)
        locator_reg <= wdata_sync_reg;
      if (index_reg == IDX_FUNC_SEL)
        func_sel_reg <= wdata_sync_reg;
      if (index_reg == IDX_POWER)
        power_reg <= wdata_sync_reg;
    end
  end

  // Banked per-function registers, written through the function select.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      active_reg <= '0;
      for (int i = 0; i < NFUNC; i++)
      begin
        range_chk_reg[i] <= 2'h0;
        base_reg[i] <= 16'h0000;
        irq_level_reg[i] <= IRQ_NONE;
        dma_cap_reg[i] <= DMA_NONE;
        dma_play_reg[i] <= DMA_NONE;
      end
    end
    else if (gl_reset)
    begin
      active_reg <= '0;
      for (int i = 0; i < NFUNC; i++)
      begin
        range_chk_reg[i] <= 2'h0;
        base_reg[i] <= 16'h0000;
        irq_level_reg[i] <= IRQ_NONE;
        dma_cap_reg[i] <= DMA_NONE;
        dma_play_reg[i] <= DMA_NONE;
      end
    end
    else if (data_wr && func_ok && (index_reg >= IDX_BANK_FIRST))
    begin
      unique case (index_reg)
        IDX_ACTIVATE: active_reg[fsel] <= wdata_sync_reg[ACTIVATE_BIT];
        IDX_RANGE_CHECK: range_chk_reg[fsel] <= wdata_sync_reg[RANGE_ENABLE_BIT:RANGE_SELECT_BIT];
        IDX_BASE_HI: base_reg[fsel][15:8] <= wdata_sync_reg;
        IDX_BASE_LO: base_reg[fsel][7:0] <= wdata_sync_reg;
        IDX_IRQ_LEVEL: irq_level_reg[fsel] <= wdata_sync_reg[3:0];
        IDX_DMA_CAPTURE:
        begin
          if (fsel != FN_LEGACY_AUDIO[2:0] || legacy_dma_ok(wdata_sync_reg[2:0]))
            dma_cap_reg[fsel] <= wdata_sync_reg[2:0];
        end
        IDX_DMA_PLAYBACK: dma_play_reg[fsel] <= wdata_sync_reg[2:0];
        default:
        begin
        end
      endcase
    end
  end

  // One range decoder per function.
  icfg_fn_if fn_if [NFUNC] ();
  for (genvar g = 0; g < NFUNC; g++)
  begin : g_fn
    assign fn_if[g].active = active_reg[g];
    assign fn_if[g].base = base_reg[g];
    assign fn_if[g].span_mask = span_of(3'(g));
    assign fn_if[g].align_mask = align_of(3'(g));
    assign fn_if[g].limit_mask = (g == 0) ? 16'hFFFF : TEN_BIT_MASK;
    assign fn_if[g].io_addr = addr_sync_reg;
    assign hit[g] = fn_if[g].hit;
    icfg_range_dec u_dec
    (
      .fn(fn_if[g])
    );
  end

  // Read answer: readback port first, then range-check answers.
  always_comb
  begin
    rd_next = ZERO_BYTE;
    rd_valid_next = 1'b0;
    if (rd_pulse && readback_hit && cfg_mode)
    begin
      rd_valid_next = 1'b1;
      if (index_reg < IDX_BANK_FIRST)
      begin
        unique case (index_reg)
          IDX_FUNC_SEL: rd_next = func_sel_reg;
          IDX_POWER: rd_next = power_reg;
          default: rd_next = ZERO_BYTE;
        endcase
      end
      else if (func_ok)
      begin
        unique case (index_reg)
          IDX_ACTIVATE: rd_next = {7'h00, active_reg[fsel]};
          IDX_RANGE_CHECK: rd_next = {6'h00, range_chk_reg[fsel]};
          IDX_BASE_HI: rd_next = base_reg[fsel][15:8];
          IDX_BASE_LO: rd_next = base_reg[fsel][7:0];
          IDX_IRQ_LEVEL: rd_next = {4'h0, irq_level_reg[fsel]};
          IDX_IRQ_TYPE: rd_next = IRQ_TYPE_VALUE;
          IDX_DMA_CAPTURE: rd_next = {5'h00, dma_cap_reg[fsel]};
          IDX_DMA_PLAYBACK: rd_next = {5'h00, dma_play_reg[fsel]};
          default: rd_next = ZERO_BYTE;
        endcase
      end
    end
    else if (rd_pulse)
    begin
      for (int i = 0; i < NFUNC; i++)
      begin
        if (hit[i] && range_chk_reg[i][RANGE_ENABLE_BIT] && !rd_valid_next)
        begin
          rd_valid_next = 1'b1;
          rd_next = range_chk_reg[i][RANGE_SELECT_BIT] ? RANGE_ANSWER_ONE : RANGE_ANSWER_ZERO;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      io_rdata <= ZERO_BYTE;
      io_rdata_valid <= 1'b0;
    end
    else
    begin
      io_rdata <= rd_next;
      io_rdata_valid <= rd_valid_next;
    end
  end

  // Function gating: inactive functions see no writes and drive no requests.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      func_active <= '0;
      func_io_write <= '0;
      func_irq_out <= '0;
      func_drq_out <= '0;
      power_saving <= ZERO_BYTE;
      codec_single_dma <= 1'b1;
    end
    else
    begin
      func_active <= active_reg;
      func_io_write <= (wr_pulse ? hit : '0) & active_reg;
      func_irq_out <= func_irq_in & active_reg;
      func_drq_out <= func_drq_in & active_reg;
      power_saving <= power_reg;
      codec_single_dma <= (dma_cap_reg[FN_CODEC[2:0]] == DMA_NONE);
    end
  end
endmodule : icfg_bank

// ==== rtl/icfg_pkg.sv ====
/*
  Constants for the configuration index bank: port addresses, indices, field positions, function codes.
  Assumes an ISA-style I/O cycle arriving as pin-level read and write strobes, synchronised to core_clk and edge-detected in the bank.
*/
package icfg_pkg;
  localparam int NFUNC = 6;
  localparam logic [15:0] INDEX_PORT_ADDR = 16'h0234;
  localparam logic [15:0] WRITE_PORT_ADDR = 16'h0235;
  localparam logic [7:0] IDX_LOCATOR = 8'h00;
  localparam logic [7:0] IDX_GLOBAL_RESET = 8'h02;
  localparam logic [7:0] IDX_FUNC_SEL = 8'h07;
  localparam logic [7:0] IDX_POWER = 8'h20;
  localparam logic [7:0] IDX_BANK_FIRST = 8'h30;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_RANGE_CHECK = 8'h31;
  localparam logic [7:0] IDX_BASE_HI = 8'h60;
  localparam logic [7:0] IDX_BASE_LO = 8'h61;
  localparam logic [7:0] IDX_IRQ_LEVEL = 8'h70;
  localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
  localparam logic [7:0] IDX_DMA_CAPTURE = 8'h74;
  localparam logic [7:0] IDX_DMA_PLAYBACK = 8'h75;
  localparam logic [7:0] IRQ_TYPE_VALUE = 8'h02;
  localparam logic [7:0] RANGE_ANSWER_ONE = 8'h55;
  localparam logic [7:0] RANGE_ANSWER_ZERO = 8'hAA;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [2:0] DMA_NONE = 3'h4;
  localparam logic [3:0] IRQ_NONE = 4'h0;
  localparam logic [5:0] LOCATOR_HIGH_ZERO = 6'h00;
  localparam logic [1:0] LOCATOR_LOW_ONES = 2'h3;
  localparam int ACTIVATE_BIT = 0;
  localparam int RANGE_SELECT_BIT = 0;
  localparam int RANGE_ENABLE_BIT = 1;
  localparam int GLOBAL_RESET_BIT = 0;
  localparam int LOCATOR_ALWAYS_ONE_BIT = 7;
  localparam logic [7:0] FN_CODEC = 8'h00;
  localparam logic [7:0] FN_LEGACY_AUDIO = 8'h01;
  localparam logic [7:0] FN_FM_SYNTH = 8'h02;
  localparam logic [7:0] FN_MIDI = 8'h03;
  localparam logic [7:0] FN_GAME_PORT = 8'h04;
  localparam logic [7:0] FN_MODEM = 8'h05;
  // Low address bits ignored by each function's decode (range size) and base alignment masks.
  localparam logic [15:0] SPAN_MASK_CODEC = 16'h0007;
  localparam logic [15:0] SPAN_MASK_LEGACY = 16'h000F;
  localparam logic [15:0] SPAN_MASK_FM = 16'h0003;
  localparam logic [15:0] SPAN_MASK_MIDI = 16'h0003;
  localparam logic [15:0] SPAN_MASK_GAME = 16'h0000;
  localparam logic [15:0] SPAN_MASK_MODEM = 16'h0007;
  localparam logic [15:0] ALIGN_MASK_CODEC = 16'h0007;
  localparam logic [15:0] ALIGN_MASK_LEGACY = 16'h000F;
  localparam logic [15:0] ALIGN_MASK_FM = 16'h0007;
  localparam logic [15:0] ALIGN_MASK_MIDI = 16'h000F;
  localparam logic [15:0] ALIGN_MASK_GAME = 16'h0000;
  localparam logic [15:0] ALIGN_MASK_MODEM = 16'h0007;
  localparam logic [15:0] TEN_BIT_MASK = 16'h03FF;
endpackage : icfg_pkg

// ==== rtl/icfg_fn_if.sv ====
/*
  Interface carrying one function's configuration from the bank to its range decoder.
  Assumes both ends run on core_clk.
*/
`timescale 1ns/1ps
interface icfg_fn_if;
  logic active;
  logic [15:0] base;
  logic [15:0] span_mask;
  logic [15:0] align_mask;
  logic [15:0] limit_mask;
  logic [15:0] io_addr;
  logic hit;
  modport bank (output active, base, span_mask, align_mask, limit_mask, io_addr, input hit);
  modport dec (input active, base, span_mask, align_mask, limit_mask, io_addr, output hit);
endinterface : icfg_fn_if

// ==== rtl/icfg_range_dec.sv ====
/*
  Address range decoder for one function: matches the I/O address against the aligned base.
  Assumes its configuration comes from the bank through icfg_fn_if; purely combinational.
*/
`timescale 1ns/1ps
module icfg_range_dec
(
  icfg_fn_if.dec fn
);
  logic [15:0] aligned_base;
  logic base_nonzero;
  always_comb
  begin
    aligned_base = fn.base & fn.limit_mask & ~fn.align_mask;
    base_nonzero = |aligned_base;
    fn.hit = base_nonzero && ((fn.io_addr & ~fn.span_mask) == (aligned_base & ~fn.span_mask));
  end
endmodule : icfg_range_dec

// ==== tb/icfg_bank_asserts.sv ====
/*
  Checker for the configuration bank: port relations of the top module.
  Assumes it is bound to icfg_bank and that the host holds each strobe six cycles.
*/
`timescale 1ns/1ps
module icfg_bank_asserts
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic arst_n,
  // Host side.
  input wire logic auto_config_select,
  input wire logic io_wr_raw,
  input wire logic io_rd_raw,
  input wire logic [7:0] io_rdata,
  input wire logic io_rdata_valid,
  // Function side.
  input wire logic [icfg_pkg::NFUNC-1:0] func_irq_in,
  input wire logic [icfg_pkg::NFUNC-1:0] func_drq_in,
  input wire logic [icfg_pkg::NFUNC-1:0] func_active,
  input wire logic [icfg_pkg::NFUNC-1:0] func_io_write,
  input wire logic [icfg_pkg::NFUNC-1:0] func_irq_out,
  input wire logic [icfg_pkg::NFUNC-1:0] func_drq_out,
  input wire logic [7:0] power_saving,
  input wire logic codec_single_dma
);
  import icfg_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  property p_irq_gated;
    func_irq_out == ($past(func_irq_in) & func_active);
  endproperty
  a_irq_gated: assert property (p_irq_gated)
    else $error("interrupt from inactive function");
  property p_drq_gated;
    func_drq_out == ($past(func_drq_in) & func_active);
  endproperty
  a_drq_gated: assert property (p_drq_gated)
    else $error("dma request from inactive function");
  property p_write_active;
    (func_io_write & ~func_active) == '0;
  endproperty
  a_write_active: assert property (p_write_active)
    else $error("range write to inactive function");
  property p_write_pulse;
    (func_io_write != '0) |=> (func_io_write == '0);
  endproperty
  a_write_pulse: assert property (p_write_pulse)
    else $error("range write longer than one cycle");
  property p_valid_pulse;
    io_rdata_valid |=> !io_rdata_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("read answer longer than one cycle");
  property p_rdata_idle;
    !io_rdata_valid |-> io_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside answer");
  property p_valid_in_read;
    io_rdata_valid |-> io_rd_raw;
  endproperty
  a_valid_in_read: assert property (p_valid_in_read)
    else $error("answer without read cycle");
  property p_auto_quiet;
    auto_config_select [*6] |-> $stable(power_saving) && $stable(func_active) && $stable(codec_single_dma);
  endproperty
  a_auto_quiet: assert property (p_auto_quiet)
    else $error("configuration changed in auto configuration mode");
  property p_quiet_stable;
    (!io_wr_raw) [*8] |-> $stable(power_saving) && $stable(func_active) && $stable(codec_single_dma);
  endproperty
  a_quiet_stable: assert property (p_quiet_stable)
    else $error("configuration changed without a write");
endmodule : icfg_bank_asserts

// ==== tb/icfg_host_model.sv ====
/*
  Host processor model issuing I/O cycles to the bank.
  Assumes tasks are entered just after a core_clk rising edge.
*/
`timescale 1ns/1ps
module icfg_host_model
(
  // Clock.
  input wire logic core_clk,
  // Host I/O cycle.
  output logic io_wr_raw,
  output logic io_rd_raw,
  output logic [15:0] io_addr,
  output logic [7:0] io_wdata,
  // Read answer.
  input wire logic [7:0] io_rdata,
  input wire logic io_rdata_valid
);
  initial
  begin
    io_wr_raw = 1'b0;
    io_rd_raw = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
  end
  // Holds the strobe six cycles, then idles four with inverted lines.
  task automatic cyc(input logic rd, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q,
                     output logic ok);
    q = 8'hxx;
    ok = 1'b0;
    io_addr = a;
    io_wdata = d;
    io_wr_raw = ~rd;
    io_rd_raw = rd;
    repeat (6)
    begin
      @(posedge core_clk);
      #1;
      if (io_rdata_valid === 1'b1)
      begin
        q = io_rdata;
        ok = 1'b1;
      end
    end
    io_wr_raw = 1'b0;
    io_rd_raw = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
    repeat (4) @(posedge core_clk);
    #1;
  endtask : cyc
endmodule : icfg_host_model

// ==== tb/icfg_bank_tb.sv ====
/*
  Self-checking testbench for the configuration bank.
  Assumes the host model and checker files are compiled first.
*/
`timescale 1ns/1ps
module icfg_bank_tb;
  import icfg_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic auto_sel = 1'b0;
  logic io_wr_raw, io_rd_raw, io_rdata_valid, single, ok;
  logic [15:0] io_addr, rb;
  logic [7:0] io_wdata, io_rdata, power, q;
  logic [5:0] irq_in = 6'h3F, drq_in = 6'h3F, active, hit, irq_out, drq_out, seen = 6'h00;
  int fails = 0;
  int tests_run = 0;
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) seen <= seen | hit;
  icfg_bank uut
  (
    .core_clk(core_clk), .arst_n(arst_n), .auto_config_select(auto_sel), .io_wr_raw(io_wr_raw),
    .io_rd_raw(io_rd_raw), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_rdata_valid(io_rdata_valid), .func_irq_in(irq_in), .func_drq_in(drq_in), .func_active(active),
    .func_io_write(hit), .func_irq_out(irq_out), .func_drq_out(drq_out), .power_saving(power),
    .codec_single_dma(single)
  );
  icfg_host_model host
  (
    .core_clk(core_clk), .io_wr_raw(io_wr_raw), .io_rd_raw(io_rd_raw), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid)
  );
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    host.cyc(1'b0, a, d, q, ok);
  endtask : wr
  task automatic cw(input logic [7:0] i, input logic [7:0] d);
    wr(INDEX_PORT_ADDR, i);
    wr(WRITE_PORT_ADDR, d);
  endtask : cw
  task automatic cr(input logic [7:0] i);
    wr(INDEX_PORT_ADDR, i);
    host.cyc(1'b1, rb, 8'h00, q, ok);
  endtask : cr
  task automatic t_locator();
    cw(IDX_LOCATOR, 8'h87);
    rb = 16'h021F;
    cw(IDX_POWER, 8'h3C);
    cr(IDX_POWER);
    chk("power read", 8'h3C, q);
    chk("power port", 8'h3C, power);
    cw(IDX_LOCATOR, 8'hC1);
    host.cyc(1'b1, 16'h021F, 8'h00, q, ok);
    chk("old port silent", 1'b0, ok);
    rb = 16'h0307;
    cr(IDX_POWER);
    chk("moved port", 8'h3C, q);
    wr(WRITE_PORT_ADDR, 8'h5A);
    host.cyc(1'b1, rb, 8'h00, q, ok);
    chk("index kept", 8'h5A, q);
    cr(8'h10);
    chk("unmapped", 8'h00, q);
  endtask : t_locator
  task automatic t_banked();
    for (int f = 0; f < 6; f++)
    begin
      cw(IDX_FUNC_SEL, 8'(f));
      cw(IDX_BASE_HI, 8'h02);
      cw(IDX_BASE_LO, 8'(f * 16 + 16));
      cw(IDX_IRQ_LEVEL, 8'(f < 3 ? f + 3 : f * 2 + 1));
    end
    for (int f = 0; f < 6; f++)
    begin
      cw(IDX_FUNC_SEL, 8'(f));
      cr(IDX_BASE_LO);
      chk("base low", 16'(f * 16 + 16), q);
      cr(IDX_BASE_HI);
      chk("base high", 8'h02, q);
      cr(IDX_IRQ_LEVEL);
      chk("irq level", 16'(f < 3 ? f + 3 : f * 2 + 1), q);
    end
    cw(IDX_FUNC_SEL, 8'h06);
    cr(IDX_BASE_LO);
    chk("bad select", 8'h00, q);
    cr(IDX_POWER);
    chk("global kept", 8'h5A, q);
  endtask : t_banked
  task automatic t_decode();
    cw(IDX_FUNC_SEL, FN_GAME_PORT);
    cw(IDX_BASE_LO, 8'h01);
    cw(IDX_ACTIVATE, 8'h01);
    cw(IDX_FUNC_SEL, FN_LEGACY_AUDIO);
    cw(IDX_ACTIVATE, 8'h01);
    drq_in = 6'h02;
    seen = 6'h00;
    wr(16'h0201, 8'hA5);
    chk("game hit", 6'h10, seen);
    seen = 6'h00;
    wr(16'h0200, 8'hA5);
    wr(16'h0202, 8'hA5);
    wr(16'h0230, 8'hA5);
    chk("no hit", 6'h00, seen);
    wr(16'h022F, 8'hA5);
    chk("legacy hit", 6'h02, seen);
    chk("active", 6'h12, active);
    chk("irq out", 6'h12, irq_out);
    chk("drq out", 6'h02, drq_out);
  endtask : t_decode
  task automatic t_range();
    cw(IDX_FUNC_SEL, FN_FM_SYNTH);
    cw(IDX_BASE_LO, 8'h88);
    cw(IDX_RANGE_CHECK, 8'h03);
    host.cyc(1'b1, 16'h0289, 8'h00, q, ok);
    chk("check one", 8'h55, q);
    cw(IDX_RANGE_CHECK, 8'h02);
    host.cyc(1'b1, 16'h028B, 8'h00, q, ok);
    chk("check zero", 8'hAA, q);
    host.cyc(1'b1, 16'h028C, 8'h00, q, ok);
    chk("fm span", 1'b0, ok);
  endtask : t_range
  task automatic t_dma();
    cw(IDX_FUNC_SEL, FN_CODEC);
    cw(IDX_DMA_CAPTURE, 8'h05);
    chk("dual dma", 1'b0, single);
    cw(IDX_DMA_CAPTURE, 8'h04);
    chk("single dma", 1'b1, single);
    cw(IDX_FUNC_SEL, FN_LEGACY_AUDIO);
    cw(IDX_DMA_CAPTURE, 8'h01);
    cw(IDX_DMA_CAPTURE, 8'h02);
    cr(IDX_DMA_CAPTURE);
    chk("legacy dma", 8'h01, q);
  endtask : t_dma
  task automatic t_auto();
    auto_sel = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    cw(IDX_POWER, 8'h77);
    auto_sel = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk("auto ignored", 8'h5A, power);
  endtask : t_auto
  task automatic t_reset();
    cw(IDX_GLOBAL_RESET, 8'h01);
    chk("reset active", 6'h00, active);
    chk("reset power", 8'h00, power);
    chk("reset dma", 1'b1, single);
    cw(IDX_LOCATOR, 8'h87);
    rb = 16'h021F;
    cr(IDX_BASE_LO);
    chk("reset base", 8'h00, q);
  endtask : t_reset
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (10) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    t_locator();
    t_banked();
    t_decode();
    t_range();
    t_dma();
    t_auto();
    t_reset();
    final_report();
  end
  initial
  begin
    #400000;
    fails++;
    final_report();
  end
endmodule : icfg_bank_tb
bind icfg_bank icfg_bank_asserts chk_u
(
  .core_clk(core_clk), .arst_n(arst_n), .auto_config_select(auto_config_select), .io_wr_raw(io_wr_raw),
  .io_rd_raw(io_rd_raw), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid), .func_irq_in(func_irq_in),
  .func_drq_in(func_drq_in), .func_active(func_active), .func_io_write(func_io_write),
  .func_irq_out(func_irq_out), .func_drq_out(func_drq_out), .power_saving(power_saving),
  .codec_single_dma(codec_single_dma)
);
